// File: dv/fpol_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
module fpol_ctrl_tb import fpol_pkg::*; ;
  logic clk_sys_i = 1'b0, nrst_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, unlock_grant_i = 1'b0, prog_req_i = 1'b0;
  logic [11:0] reg_addr_i = 12'h000;
  logic [7:0] reg_wdata_i = 8'h00, prog_data_i = 8'h00, reg_rdata_o, flash_rdata;
  logic [FPOL_ADDR_W-1:0] prog_addr_i = 14'h0000;
  logic prog_ack_o, prog_ok_o, cpu_idle_o, cpu_hold_o, ok, idl;
  logic [FPOL_OPT_NUM*8-1:0] option_bits_o;
  fpol_flash_s flash;
  logic [7:0] d;
  int err_count = 0, num_checks = 0, cyc = 0;
  fpol_ctrl u_fpol_ctrl (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .unlock_grant_i(unlock_grant_i), .prog_req_i(prog_req_i), .prog_addr_i(prog_addr_i),
    .prog_data_i(prog_data_i), .prog_ack_o(prog_ack_o), .prog_ok_o(prog_ok_o), .cpu_idle_o(cpu_idle_o),
    .cpu_hold_o(cpu_hold_o), .flash_o(flash), .flash_rdata_i(flash_rdata), .option_bits_o(option_bits_o));
  fpol_flash_model u_fpol_flash_model (.clk_sys_i(clk_sys_i), .flash_i(flash), .rdata_o(flash_rdata));
  always #25 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      final_report;
    end
  end
  task chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
      err_count++;
    end
  endtask
  task wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  task rd(input logic [11:0] a, output logic [7:0] v);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask
  task unlock;
    @(posedge clk_sys_i);
    unlock_grant_i <= 1'b1;
    @(posedge clk_sys_i);
    unlock_grant_i <= 1'b0;
  endtask
  // A missing acknowledge leaves ok unknown, so the caller's compare fails
  task prg(input logic [13:0] a, input logic [7:0] v, output logic k, output logic i);
    k = 1'bx;
    i = 1'b0;
    @(posedge clk_sys_i);
    prog_req_i <= 1'b1;
    prog_addr_i <= a;
    prog_data_i <= v;
    @(posedge clk_sys_i);
    prog_req_i <= 1'b0;
    for (int n = 0; n < 40; n++) begin
      #1;
      if (cpu_idle_o === 1'b1) i = 1'b1;
      if (prog_ack_o === 1'b1) begin
        k = prog_ok_o;
        break;
      end
      @(posedge clk_sys_i);
    end
  endtask
  task t_load;
    int n;
    @(posedge clk_sys_i);
    #1 chk({7'h0, cpu_hold_o}, 8'h01);
    nrst_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      #1 n++;
    end while (cpu_hold_o === 1'b1 && n < 100);
    chk(8'(n), 8'h2b);
    for (int i = 0; i < FPOL_OPT_NUM; i++) begin
      chk(option_bits_o[8*i+:8], i < 2 ? u_fpol_flash_model.mem[i] : u_fpol_flash_model.info_mem[i]);
    end
  endtask
  task t_trim;
    wr(FPOL_A_TRIM_IDX, 8'h00);
    rd(FPOL_A_TRIM_DATA, d);
    chk(d, u_fpol_flash_model.info_mem[32]);
    wr(FPOL_A_TRIM_IDX, 8'h1f);
    rd(FPOL_A_TRIM_DATA, d);
    chk(d, 8'h00);
    wr(FPOL_A_TRIM_DATA, 8'h6c);
    wr(FPOL_A_TRIM_IDX, 8'h25);
    rd(FPOL_A_TRIM_DATA, d);
    chk(d, 8'h6c);
    wr(FPOL_A_TRIM_IDX, 8'h05);
    wr(FPOL_A_TRIM_DATA, 8'h11);
    wr(FPOL_A_TRIM_IDX, 8'h1f);
    rd(FPOL_A_TRIM_DATA, d);
    chk(d, 8'h6c);
    wr(FPOL_A_TRIM_IDX, 8'h05);
    rd(FPOL_A_TRIM_DATA, d);
    chk(d, 8'h11);
  endtask
  task t_page;
    unlock;
    wr(FPOL_A_PAGE_PROT, 8'h00);
    wr(FPOL_A_FCTL, FPOL_CMD_PAGE);
    rd(FPOL_A_FCTL, d);
    chk(d & 8'h0f, 8'h0a);
    chk(u_fpol_flash_model.mem[0], FPOL_ERASED);
    prg(14'h00a0, 8'h3c, ok, idl);
    chk({7'h0, ok}, 8'h01);
    chk(u_fpol_flash_model.mem[14'h00a0], 8'h3c);
    prg(14'h0200, 8'h3c, ok, idl);
    chk({7'h0, ok}, 8'h00);
    wr(FPOL_A_FCTL, FPOL_CMD_RESET);
  endtask
  task t_mass;
    prg(14'h1234, 8'h0f, ok, idl);
    chk({7'h0, ok}, 8'h00);
    unlock;
    wr(FPOL_A_FCTL, FPOL_CMD_MASS);
    rd(FPOL_A_FCTL, d);
    chk(d & 8'h0f, 8'h09);
    prg(14'h1234, 8'h0f, ok, idl);
    chk({6'h0, ok, idl}, 8'h03);
    prg(14'h1234, 8'hf0, ok, idl);
    chk(u_fpol_flash_model.mem[14'h1234], 8'h00);
    wr(FPOL_A_FCTL, FPOL_CMD_RESET);
    rd(FPOL_A_FCTL, d);
    chk(d & 8'h0f, 8'h00);
    prg(14'h1235, 8'h00, ok, idl);
    chk({7'h0, ok}, 8'h00);
  endtask
  task t_protect;
    wr(FPOL_A_FCTL, FPOL_CMD_RESET);
    wr(FPOL_A_FCTL, FPOL_CMD_PROT);
    rd(FPOL_A_FCTL, d);
    chk(d & 8'h0f, 8'h04);
    rd(FPOL_A_PAGE_PROT, d);
    chk(d, 8'h00);
    wr(FPOL_A_PAGE_PROT, 8'h01);
    wr(FPOL_A_PAGE_PROT, 8'h00);
    wr(FPOL_A_PAGE_PROT, 8'h04);
    rd(FPOL_A_PAGE_PROT, d);
    chk(d, 8'h05);
    wr(FPOL_A_FCTL, FPOL_CMD_RESET);
    wr(FPOL_A_PAGE_PROT, 8'h03);
    rd(FPOL_A_PAGE_PROT, d);
    chk(d, 8'h03);
    wr(FPOL_A_FCTL, FPOL_CMD_PROT);
    rd(FPOL_A_PAGE_PROT, d);
    chk(d, 8'h05);
    wr(FPOL_A_FCTL, FPOL_CMD_RESET);
    unlock;
    wr(FPOL_A_PAGE_PROT, 8'h00);
    wr(FPOL_A_FCTL, FPOL_CMD_PAGE);
    rd(FPOL_A_FCTL, d);
    chk(d & 8'h13, 8'h10);
    prg(14'h0010, 8'h00, ok, idl);
    chk({7'h0, ok}, 8'h00);
    chk(u_fpol_flash_model.mem[14'h0010], 8'hff);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_sys_i);
    t_load;
    t_trim;
    t_page;
    t_mass;
    t_protect;
    final_report;
  end
endmodule // fpol_ctrl_tb
`default_nettype wire

// File: dv/fpol_flash_model.sv
`timescale 1ns/10ps
`default_nettype none
module fpol_flash_model import fpol_pkg::*; (
  input wire clk_sys_i,
  input wire fpol_flash_s flash_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:(1<<FPOL_ADDR_W)-1];
  logic [7:0] info_mem [0:63];
  logic [7:0] last;
  initial begin
    for (int i = 0; i < (1 << FPOL_ADDR_W); i++) mem[i] = FPOL_ERASED;
    mem[0] = 8'h5a;
    mem[1] = 8'ha5;
    for (int i = 0; i < 64; i++) info_mem[i] = 8'(i * 7 + 3);
    last = 8'h00;
  end
  // Idle read port shows the inverse of the last byte, never a stale copy
  always_comb rdata_o = flash_i.rd ? (flash_i.info ? info_mem[flash_i.addr[5:0]] : mem[flash_i.addr]) : ~last;
  // Erases leave the information page alone
  always @(posedge clk_sys_i) begin
    if (flash_i.rd) last <= rdata_o;
    if (flash_i.wr) mem[flash_i.addr] <= mem[flash_i.addr] & flash_i.wdata;
    if (flash_i.mass_erase) for (int j = 0; j < (1 << FPOL_ADDR_W); j++) mem[j] <= FPOL_ERASED;
    if (flash_i.page_erase) begin
      for (int j = 0; j < 512; j++) mem[{flash_i.addr[13:9], j[8:0]}] <= FPOL_ERASED;
    end
  end
endmodule // fpol_flash_model
`default_nettype wire

// File: src/fpol_ctrl.sv
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module fpol_ctrl import fpol_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic unlock_grant_i,
  input wire logic prog_req_i,
  input wire logic [FPOL_ADDR_W-1:0] prog_addr_i,
  input wire logic [7:0] prog_data_i,
  output logic prog_ack_o,
  output logic prog_ok_o,
  output logic cpu_idle_o,
  output logic cpu_hold_o,
  output fpol_flash_s flash_o,
  input wire logic [7:0] flash_rdata_i,
  output logic [FPOL_OPT_NUM*8-1:0] option_bits_o
);
  fpol_state_s r;
  fpol_state_s next_r;
  logic fctl_wr;
  logic erase_cmd;
  logic prog_allowed;
  logic [7:0] trim_cur;

  function automatic logic [2:0] sector_of(input logic [FPOL_ADDR_W-1:0] a);
    sector_of = a[FPOL_ADDR_W-1:FPOL_SECT_LSB];
  endfunction

  function automatic logic page_hit(input logic [FPOL_ADDR_W-1:0] a, input logic [7:0] ps);
    page_hit = (a[FPOL_ADDR_W-1:FPOL_PAGE_LSB] == ps[FPOL_PSEL_W-1:0]);
  endfunction

  // Same check guards page erase enable and each program request
  function automatic logic prot_hit(input logic [7:0] prot, input logic [2:0] s);
    prot_hit = prot[s];
  endfunction

  assign fctl_wr = reg_wr_i && (reg_addr_i == FPOL_A_FCTL);
  assign erase_cmd = (reg_wdata_i == FPOL_CMD_MASS) || (reg_wdata_i == FPOL_CMD_PAGE);
  assign trim_cur = r.trim[r.trim_idx];

  always_comb begin
    prog_allowed = 1'b0;
    if (r.unlocked && (r.mode != FPOL_M_NONE)) begin
      if (!prot_hit(r.sect_prot, sector_of(prog_addr_i))) begin
        prog_allowed = (r.mode == FPOL_M_MASS) || page_hit(prog_addr_i, r.page_sel);
      end
    end
  end

  always_comb begin
    next_r = r;
    next_r.ack = 1'b0;
    next_r.ok = 1'b0;
    next_r.mass_p = 1'b0;
    next_r.page_p = 1'b0;
    next_r.rdata = FPOL_ZERO_B;
    case (r.st)
      FPOL_LOAD: begin
        next_r.opt[r.load_cnt] = flash_rdata_i;
        if (r.load_cnt >= FPOL_TRIM_BASE) begin
          next_r.trim[r.load_cnt[4:0]] = flash_rdata_i;
        end
        next_r.load_cnt = r.load_cnt + 6'h01;
        if (r.load_cnt == FPOL_LOAD_LAST) begin
          next_r.st = FPOL_IDLE;
        end
      end
      FPOL_IDLE: begin
        if (prog_req_i) begin
          if (prog_allowed) begin
            next_r.st = FPOL_PRD;
            next_r.paddr = prog_addr_i;
            next_r.pdata = prog_data_i;
          end else begin
            next_r.ack = 1'b1;
          end
        end
      end
      FPOL_PRD: begin
        next_r.old = flash_rdata_i;
        next_r.wait_cnt = FPOL_PROG_LAST;
        next_r.st = FPOL_PWR;
      end
      FPOL_PWR: begin
        next_r.wait_cnt = r.wait_cnt - 8'h01;
        if (r.wait_cnt == FPOL_ZERO_B) begin
          next_r.st = FPOL_IDLE;
          next_r.ack = 1'b1;
          next_r.ok = 1'b1;
        end
      end
      default: next_r.st = FPOL_IDLE;
    endcase
    if (r.st != FPOL_LOAD) begin
      if (reg_rd_i) begin
        if (reg_addr_i == FPOL_A_TRIM_IDX) begin
          next_r.rdata = {3'h0, r.trim_idx};
        end else if (reg_addr_i == FPOL_A_TRIM_DATA) begin
          next_r.rdata = trim_cur;
        end else if (reg_addr_i == FPOL_A_FCTL) begin
          next_r.rdata[FPOL_ST_MASS] = (r.mode == FPOL_M_MASS);
          next_r.rdata[FPOL_ST_PAGE] = (r.mode == FPOL_M_PAGE);
          next_r.rdata[FPOL_ST_SEL] = r.sel_prot;
          next_r.rdata[FPOL_ST_UNLK] = r.unlocked;
          next_r.rdata[FPOL_ST_BLK] = r.blocked;
        end else if (reg_addr_i == FPOL_A_PAGE_PROT) begin
          next_r.rdata = r.sel_prot ? r.sect_prot : r.page_sel;
        end
      end
      if (reg_wr_i) begin
        if (reg_addr_i == FPOL_A_TRIM_IDX) begin
          if (reg_wdata_i <= FPOL_TRIM_MAX) begin
            next_r.trim_idx = reg_wdata_i[4:0];
          end
        end else if (reg_addr_i == FPOL_A_TRIM_DATA) begin
          next_r.trim[r.trim_idx] = reg_wdata_i;
        end else if (reg_addr_i == FPOL_A_PAGE_PROT) begin
          if (r.sel_prot) begin
            next_r.sect_prot = r.sect_prot | reg_wdata_i;
          end else begin
            next_r.page_sel = reg_wdata_i;
          end
        end else if (fctl_wr) begin
          next_r.sel_prot = (reg_wdata_i == FPOL_CMD_PROT);
          next_r.blocked = 1'b0;
          if (erase_cmd && r.unlocked) begin
            if (reg_wdata_i == FPOL_CMD_MASS) begin
              if (r.sect_prot == FPOL_ZERO_B) begin
                next_r.mode = FPOL_M_MASS;
                next_r.mass_p = 1'b1;
              end else begin
                next_r.blocked = 1'b1;
              end
            end else if (!prot_hit(r.sect_prot, r.page_sel[FPOL_PSEL_W-1:FPOL_SPP])) begin
              next_r.mode = FPOL_M_PAGE;
              next_r.page_p = 1'b1;
            end else begin
              next_r.blocked = 1'b1;
            end
          end else begin
            next_r.mode = FPOL_M_NONE;
            next_r.unlocked = 1'b0;
            next_r.blocked = erase_cmd;
          end
        end
      end
      if (r.st == FPOL_IDLE && prog_req_i && !prog_allowed) begin
        next_r.blocked = 1'b1;
      end
      if (unlock_grant_i) begin
        next_r.unlocked = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      r <= '0;
      r.st <= FPOL_LOAD;
    end else begin
      r <= next_r;
    end
  end

  always_comb begin
    flash_o = '0;
    flash_o.mass_erase = r.mass_p;
    flash_o.page_erase = r.page_p;
    flash_o.wdata = FPOL_ERASED;
    if (r.page_p) begin
      flash_o.addr = {r.page_sel[FPOL_PSEL_W-1:0], {FPOL_PAGE_LSB{1'b0}}};
    end
    case (r.st)
      FPOL_LOAD: begin
        flash_o.rd = 1'b1;
        flash_o.addr = {{(FPOL_ADDR_W-6){1'b0}}, r.load_cnt};
        flash_o.info = (r.load_cnt > FPOL_USER_LAST);
      end
      FPOL_PRD: begin
        flash_o.rd = 1'b1;
        flash_o.addr = r.paddr;
      end
      FPOL_PWR: begin
        flash_o.wr = 1'b1;
        flash_o.addr = r.paddr;
        flash_o.wdata = r.old & r.pdata;
      end
      default: flash_o.rd = 1'b0;
    endcase
  end

  assign reg_rdata_o = r.rdata;
  assign prog_ack_o = r.ack;
  assign prog_ok_o = r.ok;
  assign cpu_idle_o = (r.st == FPOL_PRD) || (r.st == FPOL_PWR);
  assign cpu_hold_o = (r.st == FPOL_LOAD);
  assign option_bits_o = r.opt;

  AST_PROT_STICKY: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $past(nrst_i) |-> ((r.sect_prot & $past(r.sect_prot)) == $past(r.sect_prot)))
    else $error("protection bit cleared");

  AST_FCTL_ZERO: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (fctl_wr && reg_wdata_i == FPOL_CMD_RESET && r.st != FPOL_LOAD && !unlock_grant_i)
    |=> (r.mode == FPOL_M_NONE && !r.sel_prot && !r.unlocked))
    else $error("00H did not reset controller");

  AST_PROT_SEL: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (fctl_wr && reg_wdata_i == FPOL_CMD_PROT && r.st != FPOL_LOAD)
    |=> r.sel_prot ##0 (reg_rd_i && reg_addr_i == FPOL_A_PAGE_PROT && !reg_wr_i)[*1]
    |=> reg_rdata_o == $past(r.sect_prot))
    else $error("protection register not reachable");

  AST_DESEL: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (fctl_wr && reg_wdata_i != FPOL_CMD_PROT && r.st != FPOL_LOAD) |=> !r.sel_prot)
    else $error("protection register still selected");

  AST_PROT_RESET: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $past(!nrst_i) |-> (r.sect_prot == FPOL_ZERO_B))
    else $error("protection not cleared by reset");

  AST_NO_PROT_WR: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    flash_o.wr |-> !prot_hit(r.sect_prot, sector_of(flash_o.addr)))
    else $error("write into protected sector");

  AST_PAGE_ONLY: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (flash_o.wr && r.mode == FPOL_M_PAGE) |-> page_hit(flash_o.addr, r.page_sel))
    else $error("write outside selected page");

  AST_ONE_TO_ZERO: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    flash_o.wr |-> ((flash_o.wdata & ~r.old) == FPOL_ZERO_B))
    else $error("program would set a bit");

  AST_CPU_IDLE: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (r.st == FPOL_IDLE && prog_req_i && prog_allowed) |=> cpu_idle_o [*2])
    else $error("processor not idled during program");

  AST_RELOCK: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (fctl_wr && !erase_cmd && r.st != FPOL_LOAD && !unlock_grant_i)
    |=> (!r.unlocked && r.mode == FPOL_M_NONE))
    else $error("flash not relocked");

  AST_TRIM_RD: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (reg_rd_i && reg_addr_i == FPOL_A_TRIM_DATA && r.st != FPOL_LOAD) |=> reg_rdata_o == $past(trim_cur))
    else $error("trim read wrong byte");

  AST_LOAD_LEN: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (r.st == FPOL_LOAD && r.load_cnt == 6'h00) |-> cpu_hold_o ##42 cpu_hold_o ##1 !cpu_hold_o)
    else $error("option load not 43 cycles");

  COV_LOAD_DONE: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $fell(cpu_hold_o));
  COV_PROG_OK: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    prog_ack_o && prog_ok_o);
  COV_PROG_BLOCKED: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    prog_ack_o && !prog_ok_o);
  COV_PROT_SET: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    r.sel_prot && r.sect_prot != FPOL_ZERO_B);
endmodule // fpol_ctrl
`default_nettype wire

// File: src/fpol_pkg.sv
// Summary of operation
// - Protection register bits only set by writes; written zeros never clear them.
// - Control write of 00H returns the flash controller to reset state.
// - After control write 5EH, location FF9H reaches the protection register.
// - Any other control write gives FF9H back to the page select register.
// - Reset clears the protection register, leaving all sectors unprotected.
// - Program and erase into a protected sector are blocked.
// - Programming needs unlock plus mass or page erase; mass opens all memory.
// - Page erase opens programming only inside the selected page.
// - Erased byte reads FFH; programming only turns ones into zeros.
// - Processor idles during a byte program; clock and peripherals keep running.
// - Control writes other than erase commands leave programming and relock.
// - User option bytes are the first two program bytes, erased with page 0.
// - Trim bytes live in the information page; working copies lost on power loss.
// - Thirty-two working trim bytes; index 00H-1FH then data write updates it.
// - After index load, a data read returns the indexed working trim byte.
// - Trim indices 00H-0AH load from information addresses 20-2A; indices 0BH-1FH reset to zero.
// - Load reads 43 flash bytes in 43 cycles; counter drives six address bits.
// - Option registers indexed by the counter capture read data each oscillator edge.
// - Option bytes 0 and 1 come from program memory, the rest from information.
package fpol_pkg;
  localparam int FPOL_ADDR_W = 14;
  localparam int FPOL_SECT_LSB = 11;
  localparam int FPOL_PAGE_LSB = 9;
  localparam int FPOL_PSEL_W = FPOL_ADDR_W - FPOL_PAGE_LSB;
  localparam int FPOL_SPP = FPOL_SECT_LSB - FPOL_PAGE_LSB;
  localparam logic [11:0] FPOL_A_TRIM_IDX = 12'hff6;
  localparam logic [11:0] FPOL_A_TRIM_DATA = 12'hff7;
  localparam logic [11:0] FPOL_A_FCTL = 12'hff8;
  localparam logic [11:0] FPOL_A_PAGE_PROT = 12'hff9;
  localparam logic [7:0] FPOL_CMD_RESET = 8'h00;
  localparam logic [7:0] FPOL_CMD_PROT = 8'h5e;
  localparam logic [7:0] FPOL_CMD_MASS = 8'h63;
  localparam logic [7:0] FPOL_CMD_PAGE = 8'h95;
  localparam logic [7:0] FPOL_ERASED = 8'hff;
  localparam logic [7:0] FPOL_ZERO_B = 8'h00;
  localparam logic [7:0] FPOL_TRIM_MAX = 8'h1f;
  localparam int FPOL_TRIM_NUM = 32;
  localparam int FPOL_OPT_NUM = 43;
  localparam logic [5:0] FPOL_LOAD_LAST = 6'h2a;
  localparam logic [5:0] FPOL_USER_LAST = 6'h01;
  localparam logic [5:0] FPOL_TRIM_BASE = 6'h20;
  localparam int FPOL_CLK_MHZ = 20;
  localparam int FPOL_PROG_NS = 1000;
  localparam int FPOL_PROG_CYC = (FPOL_PROG_NS * FPOL_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] FPOL_PROG_LAST = 8'(FPOL_PROG_CYC - 1);
  localparam int FPOL_ST_MASS = 0;
  localparam int FPOL_ST_PAGE = 1;
  localparam int FPOL_ST_SEL = 2;
  localparam int FPOL_ST_UNLK = 3;
  localparam int FPOL_ST_BLK = 4;

  typedef enum logic [1:0] {FPOL_LOAD, FPOL_IDLE, FPOL_PRD, FPOL_PWR} fpol_st_e;
  typedef enum logic [1:0] {FPOL_M_NONE, FPOL_M_MASS, FPOL_M_PAGE} fpol_mode_e;

  typedef struct packed {
    logic [FPOL_ADDR_W-1:0] addr;
    logic info;
    logic rd;
    logic wr;
    logic [7:0] wdata;
    logic mass_erase;
    logic page_erase;
  } fpol_flash_s;

  typedef struct packed {
    fpol_st_e st;
    logic [5:0] load_cnt;
    logic unlocked;
    logic sel_prot;
    logic blocked;
    fpol_mode_e mode;
    logic [7:0] sect_prot;
    logic [7:0] page_sel;
    logic [4:0] trim_idx;
    logic [7:0] rdata;
    logic [FPOL_TRIM_NUM-1:0][7:0] trim;
    logic [FPOL_OPT_NUM-1:0][7:0] opt;
    logic [FPOL_ADDR_W-1:0] paddr;
    logic [7:0] pdata;
    logic [7:0] old;
    logic [7:0] wait_cnt;
    logic ack;
    logic ok;
    logic mass_p;
    logic page_p;
  } fpol_state_s;
endpackage
